// file: bench/sdi_host_model.sv
// serial host model that frames words into the converter front end
`timescale 1ns/1ps
module sdi_host_model (
  output logic            o_shift_clock,
  output logic            o_frame_select_n,
  output logic            o_serial_data_in,
  input  wire logic       i_serial_data_out,
  input  wire logic       i_serial_data_out_oe_n
);
  initial begin
    o_shift_clock = 1'b1;
    o_frame_select_n = 1'b1;
    o_serial_data_in = 1'b0;
  end
  // n other than 24 makes a deliberately broken frame
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] r);
    int k;
    r = 24'h0;
    o_frame_select_n = 1'b0;
    for (k = 0; k < n; k++) begin
      o_serial_data_in = w[23 - (k % 24)];
      #3 o_shift_clock = 1'b0;
      #3 o_shift_clock = 1'b1;
      r = {r[22:0], i_serial_data_out_oe_n ? ~r[0] : i_serial_data_out};
    end
    #3 o_frame_select_n = 1'b1;
    // line no longer held: show a changed level
    o_serial_data_in = ~o_serial_data_in;
    #30;
  endtask
endmodule // sdi_host_model

// file: bench/sdi_top_sva.sv
// assertion checker for the serial converter front end
`timescale 1ns/1ps
module sdi_top_chk (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_frame_select_n,
  input wire logic        i_load_output_n,
  input wire logic        i_clear_to_code_n,
  input wire logic        i_device_reset_n,
  input wire logic        o_serial_data_out_oe_n,
  input wire logic [15:0] o_dac_code,
  input wire logic [62:0] o_segment_on,
  input wire logic [9:0]  o_ladder_bits,
  input wire logic        o_ground_clamp,
  input wire logic        o_dac_tristate,
  input wire logic        o_offset_binary,
  input wire logic        o_feedback_parallel
);
  // cycles since the last cause that may move the output
  logic [3:0] since;
  always_ff @(posedge i_clock or posedge i_reset)
    if (i_reset) since <= 4'hf;
    else if (!i_load_output_n || !i_clear_to_code_n || !i_device_reset_n || !i_frame_select_n) since <= 4'h0;
    else if (since != 4'hf) since <= since + 4'h1;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  chk_sdo_release: assert property (i_frame_select_n |-> o_serial_data_out_oe_n)
    else $error("data out driven with select high");
  chk_ladder_direct: assert property (o_ladder_bits == o_dac_code[9:0])
    else $error("ladder bits differ from code");
  chk_segment_thermo: assert property (o_segment_on == 63'h7fffffffffffffff >> (6'd63 - o_dac_code[15:10]))
    else $error("segment thermometer wrong");
  chk_pin_reset: assert property (!i_device_reset_n [*5] |-> o_dac_code == 16'h8000 && o_ground_clamp
    && o_dac_tristate && o_feedback_parallel && !o_offset_binary) else $error("reset pin defaults missing");
  chk_reset_ignore: assert property (!i_device_reset_n [*6] |-> $stable(o_dac_code))
    else $error("output moved while reset pin low");
  chk_clear_block: assert property (!i_clear_to_code_n [*6] |-> $stable(o_dac_code))
    else $error("output moved while clear low");
  chk_stray_update: assert property ($changed(o_dac_code) |-> since < 4'h8)
    else $error("output moved without cause");
  chk_clamp_tristate: assert property (o_ground_clamp |-> o_dac_tristate)
    else $error("clamp without tristate");
endmodule // sdi_top_chk

bind sdi_top sdi_top_chk sdi_top_chk_i (.i_clock(i_clock), .i_reset(i_reset), .i_frame_select_n(i_frame_select_n),
  .i_load_output_n(i_load_output_n), .i_clear_to_code_n(i_clear_to_code_n), .i_device_reset_n(i_device_reset_n),
  .o_serial_data_out_oe_n(o_serial_data_out_oe_n), .o_dac_code(o_dac_code), .o_segment_on(o_segment_on),
  .o_ladder_bits(o_ladder_bits), .o_ground_clamp(o_ground_clamp), .o_dac_tristate(o_dac_tristate),
  .o_offset_binary(o_offset_binary), .o_feedback_parallel(o_feedback_parallel));

// file: bench/tb_sdi_top.sv
// self-checking testbench of the serial converter front end
`timescale 1ns/1ps
module tb_sdi_top;
  logic        clk;
  logic        rst;
  logic        ldn;
  logic        clrn;
  logic        rstn;
  logic        sck;
  logic        csn;
  logic        sdi;
  logic        serial_data_out;
  logic        oen;
  logic [15:0] code;
  logic [62:0] seg;
  logic [9:0]  lad;
  logic        clamp;
  logic        tris;
  logic        bin;
  logic        fbp;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  sdi_top sdi_top_i (.i_clock(clk), .i_reset(rst), .i_shift_clock(sck), .i_frame_select_n(csn),
    .i_serial_data_in(sdi), .i_load_output_n(ldn), .i_clear_to_code_n(clrn), .i_device_reset_n(rstn),
    .o_serial_data_out(serial_data_out), .o_serial_data_out_oe_n(oen), .o_dac_code(code), .o_segment_on(seg),
    .o_ladder_bits(lad), .o_ground_clamp(clamp), .o_dac_tristate(tris), .o_offset_binary(bin),
    .o_feedback_parallel(fbp));
  sdi_host_model sdi_host_model_i (.o_shift_clock(sck), .o_frame_select_n(csn), .o_serial_data_in(sdi),
    .i_serial_data_out(serial_data_out), .i_serial_data_out_oe_n(oen));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // readback compared only where the expected word has bit 23 set
  task automatic ex(input logic [23:0] w, input int n, input logic [23:0] e);
    logic [23:0] r;
    sdi_host_model_i.frame(w, n, r);
    if (e[23] === 1'b1) check("readback", 64'(r), 64'(e));
  endtask
  task automatic out_is(input logic [15:0] e);
    repeat (8) @(posedge clk);
    check("code", 64'(code), 64'(e));
    check("segments", 64'(seg), 64'(63'h7fffffffffffffff >> (6'd63 - e[15:10])));
    check("ladder", 64'(lad), 64'(e[9:0]));
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    ldn = 1'b1;
    clrn = 1'b1;
    rstn = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("oe", 64'(oen), 64'h1);
    check("ctl", 64'({clamp, tris, bin, fbp}), 64'hd);
    out_is(16'h8000);
    ex(24'ha00000, 24, 24'h0);
    ex(24'hb00000, 24, 24'ha0000e);
    ex(24'h900000, 24, 24'hb00000);
    ex(24'h000000, 24, 24'h900000);
    fin("defaults");
    ex(24'h200010, 24, 24'h0);
    check("ctl", 64'({clamp, tris, bin, fbp}), 64'h2);
    @(posedge clk) ldn <= 1'b0;
    ex(24'h1c3a5f, 24, 24'h0);
    out_is(16'hc3a5);
    ex(24'h900000, 24, 24'h0);
    ex(24'h000000, 24, 24'h9c3a50);
    @(posedge clk) ldn <= 1'b1;
    ex(24'h112340, 24, 24'h0);
    out_is(16'hc3a5);
    @(posedge clk) ldn <= 1'b0;
    out_is(16'h1234);
    ex(24'h1ffff0, 23, 24'h0);
    ex(24'h1ffff0, 25, 24'h0);
    out_is(16'h1234);
    fin("update");
    ex(24'h30f0f0, 24, 24'h0);
    @(posedge clk) clrn <= 1'b0;
    out_is(16'h0f0f);
    ex(24'h1aaaa0, 24, 24'h0);
    out_is(16'h0f0f);
    @(posedge clk) ldn <= 1'b1;
    clrn <= 1'b1;
    out_is(16'h0f0f);
    ex(24'h900000, 24, 24'h0);
    ex(24'h000000, 24, 24'h90f0f0);
    @(posedge clk) ldn <= 1'b0;
    ex(24'h155550, 24, 24'h0);
    out_is(16'h5555);
    ex(24'h400002, 24, 24'h0);
    out_is(16'h0f0f);
    fin("clear");
    ex(24'h200030, 24, 24'h0);
    check("ctl", 64'({clamp, tris, bin, fbp}), 64'h2);
    ex(24'ha00000, 24, 24'h0);
    // pin left released: the host model reads its alternating idle pattern
    ex(24'h000000, 24, 24'haaaaaa);
    @(posedge clk) ldn <= 1'b1;
    ex(24'h1abcd0, 24, 24'h0);
    out_is(16'h0f0f);
    ex(24'h400001, 24, 24'h0);
    out_is(16'habcd);
    fin("disable and load");
    ex(24'h400004, 24, 24'h0);
    out_is(16'h8000);
    ex(24'ha00000, 24, 24'h0);
    ex(24'h000000, 24, 24'ha0000e);
    ex(24'h200010, 24, 24'h0);
    @(posedge clk) rstn <= 1'b0;
    repeat (6) @(posedge clk);
    ex(24'h200000, 24, 24'h0);
    @(posedge clk) rstn <= 1'b1;
    out_is(16'h8000);
    check("ctl", 64'({clamp, tris, bin, fbp}), 64'hd);
    fin("reset");
    test_done();
  end
endmodule // tb_sdi_top

// file: logic/sdi_top.sv
// serial three-wire register interface and output update control of a 16-bit converter
`timescale 1ns/1ps
// How it works
// - 24-bit frame, msb first, one bit/clock
// - bit 23 r/w, 22:20 address, 19:0 payload
// - writes: 1 code, 2 control, 3 clearcode, 4 swctl
// - reads: 1 code, 2 control, 3 clearcode
// - address 0 changes nothing
// - short or long frames are discarded
// - frame taken on select rising edge
// - payload moves to addressed register automatically
// - next frame shifts read data out
// - data out released while select high
// - read frame also returns previous read
// - data out enable defaults on
// - load low: update at select rise
// - load high: update at load fall
// - reset by pin or software command
// - reset pin low holds defaults, ignores frames
// - clear low loads clearcode, blocks updates
// - after clear, output keeps clear value
// - software clear bit equals clear pin
// - code in bits 19:4, 3:0 ignored
// - six msbs thermometer, ten bits ladder
// - clearcode resets zero, follows coding
module sdi_top (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_shift_clock,
  input  wire logic        i_frame_select_n,
  input  wire logic        i_serial_data_in,
  input  wire logic        i_load_output_n,
  input  wire logic        i_clear_to_code_n,
  input  wire logic        i_device_reset_n,
  output logic             o_serial_data_out,
  output logic             o_serial_data_out_oe_n,
  output logic [15:0]      o_dac_code,
  output logic [62:0]      o_segment_on,
  output logic [9:0]       o_ladder_bits,
  output logic             o_ground_clamp,
  output logic             o_dac_tristate,
  output logic             o_offset_binary,
  output logic             o_feedback_parallel
);

  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic [23:0] shift;
    logic [4:0]  count;
  } sdi_link_t;

  typedef struct packed {
    logic        fresh;
    logic        drive_n;
    logic        serial_data_out;
    logic [22:0] out;
  } sdi_frame_t;

  typedef struct packed {
    logic        sel_m;
    logic        sel_s;
    logic        sel_d;
    logic        rst_m;
    logic        rst_s;
    logic        ld_m;
    logic        ld_s;
    logic        ld_d;
    logic        clr_m;
    logic        clr_s;
    logic [15:0] code;
    logic [19:0] ctrl;
    logic [15:0] clrcode;
    logic [15:0] latched;
    logic [23:0] rd_word;
    logic        rd_drive;
    logic [15:0] sw_code;
    logic [62:0] seg;
    logic [9:0]  ladder;
    logic        clamp;
    logic        tri_out;
    logic        bin;
    logic        rbuf;
  } sdi_sys_t;

  sdi_link_t  lk;
  sdi_link_t  next_lk;
  sdi_frame_t fr;
  sdi_frame_t next_fr;
  sdi_sys_t   s;
  sdi_sys_t   next_s;

  // ****************************************
  // derived constants
  // ****************************************
  localparam int          FRAME_MSB = sdi_pkg::SDI_FRAME_BITS - 1;
  localparam int          CODE_MSB  = sdi_pkg::SDI_CODE_W - 1;
  localparam int          SEG_LSB   = sdi_pkg::SDI_CODE_W - sdi_pkg::SDI_SEG_BITS;
  // output code after any reset, in whatever coding the reset control value selects
  localparam logic [15:0] RESET_OUT = sdi_pkg::SDI_CTRL_RESET[sdi_pkg::SDI_CTRL_BIN] ? sdi_pkg::SDI_CODE_RESET
                                      : (sdi_pkg::SDI_CODE_RESET ^ sdi_pkg::SDI_TWOS_FLIP);
  localparam logic [62:0] SEG_FULL  = '1;
  localparam logic [62:0] RESET_SEG = SEG_FULL >> (sdi_pkg::SDI_SEG_N - int'(RESET_OUT[CODE_MSB:SEG_LSB]));

  localparam sdi_frame_t FRAME_IDLE = '{
    fresh:   1'b1,
    drive_n: 1'b1,
    serial_data_out:     1'b0,
    out:     '0
  };

  // pin synchronisers start at the idle level of their pins, so reset release shows no false edge
  localparam sdi_sys_t SYS_RESET = '{
    sel_m:    1'b1,
    sel_s:    1'b1,
    sel_d:    1'b1,
    rst_m:    1'b1,
    rst_s:    1'b1,
    ld_m:     1'b1,
    ld_s:     1'b1,
    ld_d:     1'b1,
    clr_m:    1'b1,
    clr_s:    1'b1,
    code:     sdi_pkg::SDI_CODE_RESET,
    ctrl:     sdi_pkg::SDI_CTRL_RESET,
    clrcode:  sdi_pkg::SDI_CLRC_RESET,
    latched:  sdi_pkg::SDI_CODE_RESET,
    rd_word:  '0,
    rd_drive: 1'b0,
    sw_code:  RESET_OUT,
    seg:      RESET_SEG,
    ladder:   RESET_OUT[sdi_pkg::SDI_LADDER_W-1:0],
    clamp:    sdi_pkg::SDI_CTRL_RESET[sdi_pkg::SDI_CTRL_OPGND],
    tri_out:  sdi_pkg::SDI_CTRL_RESET[sdi_pkg::SDI_CTRL_OPGND] | sdi_pkg::SDI_CTRL_RESET[sdi_pkg::SDI_CTRL_DACTRI],
    bin:      sdi_pkg::SDI_CTRL_RESET[sdi_pkg::SDI_CTRL_BIN],
    rbuf:     sdi_pkg::SDI_CTRL_RESET[sdi_pkg::SDI_CTRL_RBUF]
  };

  // ****************************************
  // link domain: shift in
  // ****************************************
  // select is timed by the host against the shift clock, so it is used as-is here
  always_comb begin
    next_lk = lk;
    if (!i_frame_select_n) begin
      next_lk.shift = {lk.shift[FRAME_MSB-1:0], i_serial_data_in};
      // count stops one past full, so a long frame can never wrap back to a valid count
      if (fr.fresh) begin
        next_lk.count = sdi_pkg::SDI_COUNT_ONE;
      end else if (lk.count != sdi_pkg::SDI_COUNT_OVER) begin
        next_lk.count = lk.count + sdi_pkg::SDI_COUNT_ONE;
      end
    end
  end

  // shift and count stay frozen while select is high; the system side reads them then
  always_ff @(negedge i_shift_clock or posedge i_reset) begin
    if (i_reset) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ****************************************
  // link domain: read data out
  // ****************************************
  // read word and drive flag are changed by the system side only while select is high, or by the reset pin at any time
  always_comb begin
    next_fr       = fr;
    next_fr.fresh = 1'b0;
    // read word is taken once, at the first fall of a frame
    if (fr.fresh) begin
      next_fr.drive_n = ~s.rd_drive;
      next_fr.serial_data_out     = s.rd_word[FRAME_MSB];
      next_fr.out     = s.rd_word[FRAME_MSB-1:0];
    end else begin
      next_fr.serial_data_out = fr.out[FRAME_MSB-1];
      next_fr.out = {fr.out[FRAME_MSB-2:0], 1'b0};
    end
  end

  // select high releases the pin at once, with no shift clock needed
  always_ff @(negedge i_shift_clock or posedge i_reset or posedge i_frame_select_n) begin
    if (i_reset || i_frame_select_n) begin
      fr <= FRAME_IDLE;
    end else begin
      fr <= next_fr;
    end
  end

  // ****************************************
  // system domain
  // ****************************************
  logic        frame_end;
  logic        frame_ok;
  logic        rw;
  logic [2:0]  addr;
  logic [19:0] pay;
  logic        sw_load;
  logic        sw_clear;
  logic        sw_reset;
  logic        update;
  logic        read_hit;
  logic [19:0] rd_data;

  always_comb begin
    next_s       = s;
    next_s.sel_m = i_frame_select_n;
    next_s.sel_s = s.sel_m;
    next_s.sel_d = s.sel_s;
    next_s.rst_m = i_device_reset_n;
    next_s.rst_s = s.rst_m;
    next_s.ld_m  = i_load_output_n;
    next_s.ld_s  = s.ld_m;
    next_s.ld_d  = s.ld_s;
    next_s.clr_m = i_clear_to_code_n;
    next_s.clr_s = s.clr_m;

    // link registers are read only while select is high, when the host holds the shift clock still
    frame_end = s.sel_s & ~s.sel_d;
    // a wrong edge count leaves every register and the pending read alone
    frame_ok  = frame_end && (lk.count == sdi_pkg::SDI_COUNT_FULL);
    rw        = lk.shift[sdi_pkg::SDI_RW_BIT];
    addr      = lk.shift[sdi_pkg::SDI_ADDR_MSB:sdi_pkg::SDI_ADDR_LSB];
    pay       = lk.shift[sdi_pkg::SDI_PAY_MSB:0];
    sw_load   = 1'b0;
    sw_clear  = 1'b0;
    sw_reset  = 1'b0;
    update    = 1'b0;
    read_hit  = 1'b0;
    rd_data   = '0;

    if (frame_ok) begin
      if (!rw) begin
        unique case (addr)
          sdi_pkg::SDI_ADDR_CODE: begin
            next_s.code = pay[sdi_pkg::SDI_PAY_MSB:sdi_pkg::SDI_CODE_LSB];
            update      = ~s.ld_s;
          end
          sdi_pkg::SDI_ADDR_CTRL: begin
            next_s.ctrl = pay;
          end
          sdi_pkg::SDI_ADDR_CLRC: begin
            next_s.clrcode = pay[sdi_pkg::SDI_PAY_MSB:sdi_pkg::SDI_CODE_LSB];
          end
          sdi_pkg::SDI_ADDR_SWC: begin
            sw_load  = pay[sdi_pkg::SDI_SWC_LOAD];
            sw_clear = pay[sdi_pkg::SDI_SWC_CLEAR];
            sw_reset = pay[sdi_pkg::SDI_SWC_RESET];
          end
          default: begin
          end
        endcase
      end else begin
        unique case (addr)
          sdi_pkg::SDI_ADDR_CODE: begin
            read_hit = 1'b1;
            rd_data  = {s.code, sdi_pkg::SDI_CODE_PAD};
          end
          sdi_pkg::SDI_ADDR_CTRL: begin
            read_hit = 1'b1;
            rd_data  = s.ctrl;
          end
          sdi_pkg::SDI_ADDR_CLRC: begin
            read_hit = 1'b1;
            rd_data  = {s.clrcode, sdi_pkg::SDI_CODE_PAD};
          end
          default: begin
          end
        endcase
      end
      // a read word is offered to each frame up to the next valid one, then dropped
      next_s.rd_drive = read_hit & ~s.ctrl[sdi_pkg::SDI_CTRL_SDODIS];
      if (read_hit) begin
        next_s.rd_word = {rw, addr, rd_data};
      end
    end

    // async mode: load falling while select is high
    // a software load acts as a load fall
    if ((~s.ld_s & s.ld_d & s.sel_s) || sw_load) begin
      update = 1'b1;
    end
    if (update) begin
      next_s.latched = next_s.code;
    end

    // pin clear is level held, so it also blocks every update while low
    if (!s.clr_s || sw_clear) begin
      next_s.code    = next_s.clrcode;
      next_s.latched = next_s.clrcode;
    end

    // reset pin held low pins every register to its default each cycle
    if (sw_reset || !s.rst_s) begin
      next_s.code     = sdi_pkg::SDI_CODE_RESET;
      next_s.ctrl     = sdi_pkg::SDI_CTRL_RESET;
      next_s.clrcode  = sdi_pkg::SDI_CLRC_RESET;
      next_s.latched  = sdi_pkg::SDI_CODE_RESET;
      next_s.rd_drive = 1'b0;
      next_s.rd_word  = '0;
    end

    // clear value follows whatever coding is selected at the output
    next_s.bin     = next_s.ctrl[sdi_pkg::SDI_CTRL_BIN];
    next_s.sw_code = next_s.bin ? next_s.latched : (next_s.latched ^ sdi_pkg::SDI_TWOS_FLIP);
    // segment i is on when the six msbs exceed i
    for (int i = 0; i < sdi_pkg::SDI_SEG_N; i++) begin
      next_s.seg[i] = (next_s.sw_code[CODE_MSB:SEG_LSB] > 6'(i));
    end
    next_s.ladder  = next_s.sw_code[sdi_pkg::SDI_LADDER_W-1:0];
    next_s.clamp   = next_s.ctrl[sdi_pkg::SDI_CTRL_OPGND];
    next_s.tri_out = next_s.ctrl[sdi_pkg::SDI_CTRL_OPGND] | next_s.ctrl[sdi_pkg::SDI_CTRL_DACTRI];
    next_s.rbuf    = next_s.ctrl[sdi_pkg::SDI_CTRL_RBUF];
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s <= SYS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_serial_data_out      = fr.serial_data_out;
  assign o_serial_data_out_oe_n = fr.drive_n;
  assign o_dac_code             = s.sw_code;
  assign o_segment_on           = s.seg;
  assign o_ladder_bits          = s.ladder;
  assign o_ground_clamp         = s.clamp;
  assign o_dac_tristate         = s.tri_out;
  assign o_offset_binary        = s.bin;
  assign o_feedback_parallel    = s.rbuf;

endmodule // sdi_top

// file: shared/sdi_pkg.sv
// constants shared by the serial converter control front end
package sdi_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int          SDI_FRAME_BITS = 24;
  localparam int          SDI_COUNT_W    = 5;
  localparam logic [4:0]  SDI_COUNT_ONE  = 5'h01;
  localparam logic [4:0]  SDI_COUNT_FULL = 5'h18;
  localparam logic [4:0]  SDI_COUNT_OVER = 5'h19;
  localparam int          SDI_RW_BIT     = 23;
  localparam int          SDI_ADDR_MSB   = 22;
  localparam int          SDI_ADDR_LSB   = 20;
  localparam int          SDI_PAY_W      = 20;
  localparam int          SDI_PAY_MSB    = 19;
  localparam int          SDI_CODE_W     = 16;
  localparam int          SDI_CODE_LSB   = 4;
  localparam logic [3:0]  SDI_CODE_PAD   = 4'h0;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [2:0]  SDI_ADDR_NOP   = 3'h0;
  localparam logic [2:0]  SDI_ADDR_CODE  = 3'h1;
  localparam logic [2:0]  SDI_ADDR_CTRL  = 3'h2;
  localparam logic [2:0]  SDI_ADDR_CLRC  = 3'h3;
  localparam logic [2:0]  SDI_ADDR_SWC   = 3'h4;

  // ****************************************
  // control and software control fields
  // ****************************************
  localparam int          SDI_CTRL_RBUF   = 1;
  localparam int          SDI_CTRL_OPGND  = 2;
  localparam int          SDI_CTRL_DACTRI = 3;
  localparam int          SDI_CTRL_BIN    = 4;
  localparam int          SDI_CTRL_SDODIS = 5;
  localparam logic [19:0] SDI_CTRL_RESET  = 20'h0000e;
  localparam logic [15:0] SDI_CLRC_RESET  = 16'h0000;
  localparam logic [15:0] SDI_CODE_RESET  = 16'h0000;
  localparam int          SDI_SWC_LOAD    = 0;
  localparam int          SDI_SWC_CLEAR   = 1;
  localparam int          SDI_SWC_RESET   = 2;

  // ****************************************
  // switch decode
  // ****************************************
  localparam int          SDI_SEG_N      = 63;
  localparam int          SDI_SEG_BITS   = 6;
  localparam int          SDI_LADDER_W   = 10;
  localparam logic [15:0] SDI_TWOS_FLIP  = 16'h8000;

endpackage
